// *** hw/vocoder_regs.v ***
// Behaviour
// - ack register bit 0 is one for success, zero for failure
// - frame types: two bits per frame, frame one in bits 1:0
// - frame types captured only for raw frames without FEC
// - packet register streams up to 36 bytes, msb first
// - raw packets: 6 or 7 bytes per frame, 1 to 4 frames
// - FEC packets: 27 bytes per 60ms (3 frames), 36 bytes for 1, 2 or 4 frames
// - packet register also returns codec FIFO words, high byte first
// - new control value takes effect within one 20ms frame
// - mirror register returns last control write at once
// - control write completion sets ready flag and may interrupt
// - bit 0 enables playback path
// - bit 1 enables capture path; off means no packets unless repeater bit 2 set
// - both paths set: off on half duplex, full duplex otherwise
// - repeater recode outputs packets when capture is off
// - bit 3 enables loss concealment
// - bit 4 lets decoder readiness set frame wanted flag
// - bit 5 enables dual-tone frame detection, forced off while full duplex is active
// - bit 6 generates dual tones only while detection on
// - bit 7 enables single-tone frame detection, forced off while full duplex is active
// - service completion sets service flag and ack result
`timescale 1ns/1ps
`include "vocoder_regs_map.vh"
module vocoder_regs #(
    parameter FULL_DUPLEX  = 0,
    parameter FRAME_CYCLES = `FRAME_CYCLES
) (
    input  wire        clk_in,                // core clock
    input  wire        rst_in,                // sync reset, high
    input  wire        bus_clk_in,            // host serial clock
    input  wire        bus_cs_n_in,           // host select, low
    input  wire        bus_cmd_in,            // host serial data in
    output reg         bus_reply_out,         // serial reply data
    input  wire [7:0]  vocoder_config_in,     // config register value
    input  wire [7:0]  pkt_byte_in,           // encoder output byte
    input  wire        pkt_byte_valid_in,     // encoder byte strobe
    input  wire [7:0]  frame_types_in,        // encoder frame types
    input  wire        frame_types_valid_in,  // frame types strobe
    input  wire        svc_done_in,           // service finished pulse
    input  wire        svc_ok_in,             // service result
    input  wire        decoder_ready_in,      // decoder can take frame
    input  wire        codec_fifo_sel_in,     // stream codec FIFO
    input  wire [15:0] codec_fifo_word_in,    // codec FIFO head word
    input  wire        status_clear_in,       // clears sticky flags
    input  wire [1:0]  irq_enable_in,         // [0] service, [1] ready
    output reg         codec_fifo_pop_out,    // FIFO word consumed
    output reg         packet_due_out,        // produce packet pulse
    output reg         playback_path_on_out,  // decoder enable
    output reg         capture_path_on_out,   // encoder enable
    output reg         repeater_recode_on_out,// repeater enable
    output reg         loss_concealment_on_out, // concealment enable
    output reg         rx_dual_tone_detect_out, // dual-tone detect
    output reg         rx_dual_tone_generate_out, // dual-tone gen
    output reg         rx_single_tone_detect_out, // single-tone det
    output reg         full_duplex_out,       // full duplex active
    output reg         packet_available_flag_out, // packet ready
    output reg         frame_wanted_flag_out, // decoder wants frame
    output reg         service_done_flag_out, // service completed
    output reg         control_done_flag_out, // control applied
    output wire        interrupt_request_low_out // interrupt, low
);
    localparam BW = 6;

    wire       bclk_s;
    wire       cs_n_s;
    wire       cmd_s;
    reg        bclk_d_reg;
    wire       bclk_rise = bclk_s & ~bclk_d_reg;
    wire       bclk_fall = ~bclk_s & bclk_d_reg;

    // synchronisers reset to the idle level, so no false edge after reset
    sync_2ff u_sync_clk (.clk_in(clk_in), .rst_in(rst_in), .d_in(bus_clk_in),
        .rst_val_in(1'b0), .q_out(bclk_s));
    sync_2ff u_sync_cs (.clk_in(clk_in), .rst_in(rst_in), .d_in(bus_cs_n_in),
        .rst_val_in(1'b1), .q_out(cs_n_s));
    sync_2ff u_sync_cmd (.clk_in(clk_in), .rst_in(rst_in), .d_in(bus_cmd_in),
        .rst_val_in(1'b0), .q_out(cmd_s));

    reg [15:0] control_reg;
    reg [15:0] mirror_reg;
    reg        pending_reg;
    reg [7:0]  ack_reg;
    reg [7:0]  types_reg;
    reg [4:0]  bit_cnt_reg;
    reg        addr_done_reg;
    reg [7:0]  addr_reg;
    reg [15:0] shift_in_reg;
    reg [15:0] reply_reg;
    reg        fifo_low_reg;
    reg [BW-1:0] wr_ptr_reg;
    reg [BW-1:0] rd_ptr_reg;
    wire [7:0]   rd_byte;
    reg [31:0] frame_cnt_reg;
    reg [2:0]  pkt_frame_reg;
    wire       frame_tick = (frame_cnt_reg == FRAME_CYCLES - 1);

    // packet size from config
    wire       fec_on = vocoder_config_in[`CFG_FEC];
    wire [1:0] rate = vocoder_config_in[`CFG_RATE_HI:`CFG_RATE_LO];
    wire [1:0] fsel = vocoder_config_in[`CFG_FRAMES_HI:`CFG_FRAMES_LO];
    wire [2:0] frames = (fsel == 2'h0) ? 3'h4 : {1'b0, fsel};
    wire [BW-1:0] per_frame = (rate == `CFG_RATE_2750) ?
                              `BYTES_2750 : `BYTES_2400;
    reg  [BW-1:0] byte_count;

    always @* begin
        if (fec_on) begin
            byte_count = (frames == 3'h3) ?
                         `BYTES_FEC_3 : `BYTES_FEC_4;
        end else begin
            byte_count = per_frame * {3'h0, frames};
        end
    end

    // capture or repeater path feeds the packet register
    wire producing = capture_path_on_out |
                     (repeater_recode_on_out &
                      ~control_reg[`CTL_CAPTURE]);
    wire store_wr = pkt_byte_valid_in & producing;
    wire last_byte = store_wr & (wr_ptr_reg == byte_count - 1'b1);

    packet_store #(.DEPTH(`PACKET_MAX_BYTES), .AW(BW)) u_store (.clk_in(clk_in),
        .wr_en_in(store_wr), .wr_addr_in(wr_ptr_reg), .wr_data_in(pkt_byte_in),
        .rd_addr_in(rd_ptr_reg), .rd_data_out(rd_byte));

    // read mux for the address being loaded
    wire [7:0] next_addr = {shift_in_reg[6:0], cmd_s};
    wire [7:0] sel_addr  = addr_done_reg ? addr_reg : next_addr;
    reg  [15:0] read_word;
    wire [7:0]  stream_byte = codec_fifo_sel_in ?
        (fifo_low_reg ? codec_fifo_word_in[7:0] :
                        codec_fifo_word_in[15:8]) : rd_byte;

    always @* begin
        case (sel_addr)
            `ADDR_SERVICE_ACK:    read_word = {ack_reg, 8'h00};
            `ADDR_FRAME_TYPES:    read_word = {types_reg, 8'h00};
            `ADDR_PACKET_STREAM:  read_word = {stream_byte, 8'h00};
            `ADDR_CONTROL_MIRROR: read_word = mirror_reg;
            default:              read_word = 16'h0000;
        endcase
    end

    wire addr_end = bclk_rise & ~cs_n_s & ~addr_done_reg &
                    (bit_cnt_reg == 5'h07);
    wire stream_end = bclk_rise & ~cs_n_s & addr_done_reg &
                      (addr_reg == `ADDR_PACKET_STREAM) &
                      (bit_cnt_reg == 5'h07);
    wire ctl_end = bclk_rise & ~cs_n_s & addr_done_reg &
                   (addr_reg == `ADDR_VOCODER_CONTROL) &
                   (bit_cnt_reg == 5'h0F);
    wire load_reply = addr_end | stream_end;
    wire take_byte = (addr_end & (next_addr == `ADDR_PACKET_STREAM)) |
                     stream_end;

    // serial shifter
    always @(posedge clk_in) begin
        if (rst_in) begin
            bclk_d_reg    <= 1'b0;
            bit_cnt_reg   <= 5'h00;
            addr_done_reg <= 1'b0;
            addr_reg      <= 8'h00;
            shift_in_reg  <= 16'h0000;
            reply_reg     <= 16'h0000;
            bus_reply_out <= 1'b0;
        end else begin
            bclk_d_reg <= bclk_s;
            if (cs_n_s) begin
                bit_cnt_reg   <= 5'h00;
                addr_done_reg <= 1'b0;
            end else if (bclk_rise) begin
                shift_in_reg <= {shift_in_reg[14:0], cmd_s};
                bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                if (addr_end) begin
                    addr_reg      <= next_addr;
                    addr_done_reg <= 1'b1;
                    bit_cnt_reg   <= 5'h00;
                end else if (stream_end | ctl_end) begin
                    bit_cnt_reg <= 5'h00;
                end
                if (load_reply) begin
                    reply_reg <= read_word;
                end
            end else if (bclk_fall) begin
                bus_reply_out <= reply_reg[15];
                reply_reg     <= {reply_reg[14:0], 1'b0};
            end
        end
    end

    // control word, mirror and deferred apply
    always @(posedge clk_in) begin
        if (rst_in) begin
            control_reg           <= `CONTROL_RESET;
            mirror_reg            <= `CONTROL_RESET;
            pending_reg           <= 1'b0;
            control_done_flag_out <= 1'b0;
        end else begin
            if (ctl_end) begin
                mirror_reg  <= {shift_in_reg[14:0], cmd_s};
                pending_reg <= 1'b1;
            end else if (pending_reg & frame_tick) begin
                control_reg <= mirror_reg;
                pending_reg <= 1'b0;
            end
            if (pending_reg & frame_tick & ~ctl_end) begin
                control_done_flag_out <= 1'b1;
            end else if (status_clear_in) begin
                control_done_flag_out <= 1'b0;
            end
        end
    end

    wire dec_bit = control_reg[`CTL_PLAYBACK];
    wire enc_bit = control_reg[`CTL_CAPTURE];
    wire both = dec_bit & enc_bit;
    wire fd = both & (FULL_DUPLEX != 0);
    wire tones_ok = ~fd;

    always @(posedge clk_in) begin
        if (rst_in) begin
            playback_path_on_out      <= 1'b0;
            capture_path_on_out       <= 1'b0;
            repeater_recode_on_out    <= 1'b0;
            loss_concealment_on_out   <= 1'b0;
            rx_dual_tone_detect_out   <= 1'b0;
            rx_dual_tone_generate_out <= 1'b0;
            rx_single_tone_detect_out <= 1'b0;
            full_duplex_out           <= 1'b0;
        end else begin
            playback_path_on_out    <= dec_bit & (~both | fd);
            capture_path_on_out     <= enc_bit & (~both | fd);
            repeater_recode_on_out  <= control_reg[`CTL_REPEATER] &
                                       ~enc_bit;
            loss_concealment_on_out <= control_reg[`CTL_CONCEAL];
            rx_dual_tone_detect_out <= control_reg[`CTL_RX_DT_DETECT] &
                                       tones_ok;
            rx_dual_tone_generate_out <=
                control_reg[`CTL_RX_DT_GENERATE] &
                control_reg[`CTL_RX_DT_DETECT] & tones_ok;
            rx_single_tone_detect_out <=
                control_reg[`CTL_RX_ST_DETECT] & tones_ok;
            full_duplex_out <= fd;
        end
    end

    // frame timer and packet cadence
    always @(posedge clk_in) begin
        if (rst_in) begin
            frame_cnt_reg  <= 32'h00000000;
            pkt_frame_reg  <= 3'h0;
            packet_due_out <= 1'b0;
        end else begin
            packet_due_out <= 1'b0;
            if (frame_tick) begin
                frame_cnt_reg <= 32'h00000000;
                if (!producing) begin
                    pkt_frame_reg <= 3'h0;
                end else if (pkt_frame_reg + 3'h1 >= frames) begin
                    pkt_frame_reg  <= 3'h0;
                    packet_due_out <= 1'b1;
                end else begin
                    pkt_frame_reg <= pkt_frame_reg + 3'h1;
                end
            end else begin
                frame_cnt_reg <= frame_cnt_reg + 32'h00000001;
            end
        end
    end

    // packet buffer pointers and availability
    always @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_reg                <= {BW{1'b0}};
            rd_ptr_reg                <= {BW{1'b0}};
            fifo_low_reg              <= 1'b0;
            codec_fifo_pop_out        <= 1'b0;
            packet_available_flag_out <= 1'b0;
        end else begin
            codec_fifo_pop_out <= 1'b0;
            if (!producing) begin
                wr_ptr_reg <= {BW{1'b0}};
            end else if (last_byte) begin
                wr_ptr_reg <= {BW{1'b0}};
            end else if (store_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (last_byte) begin
                rd_ptr_reg <= {BW{1'b0}};
            end else if (take_byte & ~codec_fifo_sel_in &
                         (rd_ptr_reg < byte_count - 1'b1)) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (take_byte & codec_fifo_sel_in) begin
                fifo_low_reg       <= ~fifo_low_reg;
                codec_fifo_pop_out <= fifo_low_reg;
            end
            if (last_byte) begin
                packet_available_flag_out <= 1'b1;
            end else if (status_clear_in) begin
                packet_available_flag_out <= 1'b0;
            end
        end
    end

    // service result, frame types and notifications
    always @(posedge clk_in) begin
        if (rst_in) begin
            ack_reg               <= `ACK_RESET;
            types_reg             <= `FRAME_TYPES_RESET;
            service_done_flag_out <= 1'b0;
            frame_wanted_flag_out <= 1'b0;
        end else begin
            if (svc_done_in) begin
                ack_reg               <= {7'h00, svc_ok_in};
                service_done_flag_out <= 1'b1;
            end else if (status_clear_in) begin
                service_done_flag_out <= 1'b0;
            end
            if (frame_types_valid_in & ~fec_on) begin
                types_reg <= frame_types_in;
            end
            if (decoder_ready_in &
                control_reg[`CTL_WANTED_NOTIFY]) begin
                frame_wanted_flag_out <= 1'b1;
            end else if (status_clear_in) begin
                frame_wanted_flag_out <= 1'b0;
            end
        end
    end

    assign interrupt_request_low_out =
        ~((service_done_flag_out & irq_enable_in[0]) |
          (control_done_flag_out & irq_enable_in[1]));
endmodule

// *** hw/vocoder_regs_map.vh ***
`ifndef VOCODER_REGS_MAP_VH
`define VOCODER_REGS_MAP_VH
// register addresses on the serial control bus
`define ADDR_VOCODER_CONTROL    8'h11
`define ADDR_SERVICE_ACK        8'h2E
`define ADDR_FRAME_TYPES        8'h2F
`define ADDR_PACKET_STREAM      8'h30
`define ADDR_CONTROL_MIRROR     8'h3C
// vocoder_control field positions
`define CTL_PLAYBACK            0
`define CTL_CAPTURE             1
`define CTL_REPEATER            2
`define CTL_CONCEAL             3
`define CTL_WANTED_NOTIFY       4
`define CTL_RX_DT_DETECT        5
`define CTL_RX_DT_GENERATE      6
`define CTL_RX_ST_DETECT        7
// vocoder_config field positions
`define CFG_FEC                 4
`define CFG_RATE_HI             3
`define CFG_RATE_LO             2
`define CFG_FRAMES_HI           1
`define CFG_FRAMES_LO           0
`define CFG_RATE_2750           2'h2
// packet sizes in bytes
`define BYTES_2400              6'h06
`define BYTES_2750              6'h07
`define BYTES_FEC_3             6'h1B
`define BYTES_FEC_4             6'h24
`define PACKET_MAX_BYTES        36
// reset values
`define CONTROL_RESET           16'h0000
`define ACK_RESET               8'h00
`define FRAME_TYPES_RESET       8'h00
// timing
`define CLK_MHZ                 250
`define FRAME_MS                20
`define FRAME_CYCLES            (`FRAME_MS * `CLK_MHZ * 1000)
`endif

// *** hw/sync_2ff.v ***
`timescale 1ns/1ps
module sync_2ff (
    input  wire clk_in,   // core clock
    input  wire rst_in,   // sync reset, high
    input  wire d_in,     // asynchronous level
    input  wire rst_val_in, // idle level of the pin
    output wire q_out     // synchronised level
);
    reg meta_reg;
    reg sync_reg;

    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= rst_val_in;
            sync_reg <= rst_val_in;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule

// *** hw/packet_store.v ***
`timescale 1ns/1ps
module packet_store #(
    parameter DEPTH = 36,
    parameter AW    = 6
) (
    input  wire          clk_in,     // core clock
    input  wire          wr_en_in,   // write strobe
    input  wire [AW-1:0] wr_addr_in, // write address
    input  wire [7:0]    wr_data_in, // write byte
    input  wire [AW-1:0] rd_addr_in, // read address
    output reg  [7:0]    rd_data_out // registered read byte
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

// *** dv/vocoder_regs_checker.sv ***
`timescale 1ns/1ps
module vocoder_regs_checker #(
    parameter FULL_DUPLEX = 0
) (
    input wire       clk_in,
    input wire       rst_in,
    input wire       svc_done_in,
    input wire       decoder_ready_in,
    input wire       pkt_byte_valid_in,
    input wire       status_clear_in,
    input wire [1:0] irq_enable_in,
    input wire       codec_fifo_pop_out,
    input wire       packet_due_out,
    input wire       playback_path_on_out,
    input wire       capture_path_on_out,
    input wire       repeater_recode_on_out,
    input wire       rx_dual_tone_detect_out,
    input wire       rx_dual_tone_generate_out,
    input wire       full_duplex_out,
    input wire       packet_available_flag_out,
    input wire       frame_wanted_flag_out,
    input wire       service_done_flag_out,
    input wire       control_done_flag_out,
    input wire       interrupt_request_low_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_svc_evt;
        svc_done_in ##1 service_done_flag_out;
    endsequence
    property p_svc_set; svc_done_in |-> s_svc_evt; endproperty
    property p_svc_clear; status_clear_in && !svc_done_in |=> !service_done_flag_out; endproperty
    property p_irq;
        interrupt_request_low_out == !((service_done_flag_out && irq_enable_in[0])
            || (control_done_flag_out && irq_enable_in[1]));
    endproperty
    property p_ctl_sticky; control_done_flag_out && !status_clear_in |=> control_done_flag_out; endproperty
    property p_wanted_cause; $rose(frame_wanted_flag_out) |-> $past(decoder_ready_in); endproperty
    property p_avail_cause; $rose(packet_available_flag_out) |-> $past(pkt_byte_valid_in); endproperty
    property p_pop_pulse; codec_fifo_pop_out |=> !codec_fifo_pop_out; endproperty
    property p_due_space; packet_due_out |=> !packet_due_out [*8]; endproperty
    property p_half;
        (FULL_DUPLEX == 0) |-> !(playback_path_on_out && capture_path_on_out) && !full_duplex_out;
    endproperty
    property p_repeater; repeater_recode_on_out |-> !capture_path_on_out; endproperty
    property p_dt_gen; rx_dual_tone_generate_out |-> rx_dual_tone_detect_out; endproperty
    a_svc_set: assert property (p_svc_set) else $error("service flag not set");
    a_svc_clear: assert property (p_svc_clear) else $error("service flag not cleared");
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
    a_ctl_sticky: assert property (p_ctl_sticky) else $error("control flag dropped");
    a_wanted_cause: assert property (p_wanted_cause) else $error("wanted flag uncaused");
    a_avail_cause: assert property (p_avail_cause) else $error("packet flag uncaused");
    a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than one cycle");
    a_due_space: assert property (p_due_space) else $error("packet due too often");
    a_half: assert property (p_half) else $error("both paths on");
    a_repeater: assert property (p_repeater) else $error("repeater with capture");
    a_dt_gen: assert property (p_dt_gen) else $error("tone generate without detect");
endmodule

bind vocoder_regs vocoder_regs_checker #(.FULL_DUPLEX(FULL_DUPLEX)) u_chk (.*);

// *** dv/host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model (
    input  wire  clk_in,       // core clock for pacing
    input  wire  bus_reply_in, // reply data from device
    output logic bus_clk_out,  // serial clock, still between frames
    output logic bus_cs_n_out, // select, low
    output logic bus_cmd_out   // serial data to device
);
    localparam int HALF = 10;
    initial begin
        bus_clk_out = 1'b0;
        bus_cs_n_out = 1'b1;
        bus_cmd_out = 1'b0;
    end
    // released data line wanders so stale bits are never mistaken for data
    always @(posedge clk_in) begin
        if (bus_cs_n_out)
            bus_cmd_out <= ~bus_cmd_out;
    end
    task half;
        repeat (HALF) @(posedge clk_in);
        #1;
    endtask
    task shift(input integer n, input [15:0] wd, output [15:0] rd);
        integer b;
        rd = 16'h0000;
        for (b = n - 1; b >= 0; b = b - 1) begin
            bus_cmd_out = wd[b];
            half;
            bus_clk_out = 1'b1;
            rd = {rd[14:0], bus_reply_in};
            half;
            bus_clk_out = 1'b0;
        end
    endtask
    task start(input [7:0] a);
        reg [15:0] dummy;
        bus_cs_n_out = 1'b0;
        shift(8, {8'h00, a}, dummy);
    endtask
    task stop;
        half;
        bus_cs_n_out = 1'b1;
        half;
    endtask
endmodule

// *** dv/vocoder_regs_tb.sv ***
`timescale 1ns/1ps
`include "vocoder_regs_map.vh"
module vocoder_regs_tb;
    logic        clk_in, rst_in, pkt_byte_valid_in, frame_types_valid_in, svc_done_in;
    logic        svc_ok_in, decoder_ready_in, codec_fifo_sel_in, status_clear_in;
    logic [7:0]  vocoder_config_in, pkt_byte_in, frame_types_in;
    logic [15:0] codec_fifo_word_in;
    logic [1:0]  irq_enable_in;
    wire         bus_clk, bus_cs_n, bus_cmd, bus_reply, fifo_pop, pkt_due, play_on, cap_on;
    wire         rep_on, conc_on, dt_det, dt_gen, st_det, fdx_on, avail_flag, wanted_flag;
    wire         svc_flag, ctl_flag, irq_n;
    integer      n_errors = 0, check_count = 0, seed = 32'hdedb5f4c, i, k, n, pops = 0;
    reg [15:0]   rd, v;
    reg [15:0]   vals [0:2];
    reg [7:0]    ft;
    reg [7:0]    bytes [0:35];

    host_bus_model HOST (.clk_in(clk_in), .bus_reply_in(bus_reply), .bus_clk_out(bus_clk),
        .bus_cs_n_out(bus_cs_n), .bus_cmd_out(bus_cmd));
    vocoder_regs #(.FULL_DUPLEX(0), .FRAME_CYCLES(50)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .bus_clk_in(bus_clk), .bus_cs_n_in(bus_cs_n),
        .bus_cmd_in(bus_cmd), .bus_reply_out(bus_reply), .vocoder_config_in(vocoder_config_in),
        .pkt_byte_in(pkt_byte_in), .pkt_byte_valid_in(pkt_byte_valid_in),
        .frame_types_in(frame_types_in), .frame_types_valid_in(frame_types_valid_in),
        .svc_done_in(svc_done_in), .svc_ok_in(svc_ok_in), .decoder_ready_in(decoder_ready_in),
        .codec_fifo_sel_in(codec_fifo_sel_in), .codec_fifo_word_in(codec_fifo_word_in),
        .status_clear_in(status_clear_in), .irq_enable_in(irq_enable_in),
        .codec_fifo_pop_out(fifo_pop), .packet_due_out(pkt_due), .playback_path_on_out(play_on),
        .capture_path_on_out(cap_on), .repeater_recode_on_out(rep_on),
        .loss_concealment_on_out(conc_on), .rx_dual_tone_detect_out(dt_det),
        .rx_dual_tone_generate_out(dt_gen), .rx_single_tone_detect_out(st_det),
        .full_duplex_out(fdx_on), .packet_available_flag_out(avail_flag),
        .frame_wanted_flag_out(wanted_flag), .service_done_flag_out(svc_flag),
        .control_done_flag_out(ctl_flag), .interrupt_request_low_out(irq_n));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (fifo_pop === 1'b1)
            pops = pops + 1;
    end

    function [7:0] exp_ctl(input [15:0] c);
        reg both;
        both = c[0] & c[1];
        exp_ctl = {c[7], c[6] & c[5], c[5], c[3], c[2] & ~c[1], c[1] & ~both, c[0] & ~both, 1'b0};
    endfunction
    function integer exp_bytes(input [7:0] c);
        integer f;
        f = (c[1:0] == 2'b00) ? 4 : c[1:0];
        if (c[4])
            exp_bytes = (c[1:0] == 2'b11) ? 27 : 36;
        else
            exp_bytes = f * ((c[3:2] == 2'b10) ? 7 : 6);
    endfunction
    task tick;
        @(posedge clk_in);
        #1;
    endtask
    task check(input [31:0] got, input [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_reg(input [7:0] a, input integer nb, output [15:0] r);
        HOST.start(a);
        HOST.shift(nb, 16'h0000, r);
        HOST.stop;
    endtask
    task clear_flags;
        status_clear_in = 1'b1;
        tick;
        status_clear_in = 1'b0;
    endtask
    task complete_run;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #360000;
        n_errors = n_errors + 1;
        complete_run;
    end

    initial begin
        rst_in = 1'b1;
        {pkt_byte_valid_in, frame_types_valid_in, svc_done_in, svc_ok_in, decoder_ready_in,
            codec_fifo_sel_in, status_clear_in} = 7'h00;
        {pkt_byte_in, frame_types_in, codec_fifo_word_in} = 32'h0;
        vocoder_config_in = 8'h05;
        irq_enable_in = 2'h2;
        repeat (16) tick;
        rst_in = 1'b0;
        repeat (4) tick;
        check({svc_flag, ctl_flag, avail_flag, wanted_flag, irq_n}, 5'h01);
        vals[0] = 16'h0003;
        vals[1] = 16'h0005;
        vals[2] = ($random(seed) & 16'h3BE8) | 16'h0012;
        for (i = 0; i < 3; i = i + 1) begin
            v = vals[i];
            clear_flags;
            HOST.start(`ADDR_VOCODER_CONTROL);
            HOST.shift(16, v, rd);
            HOST.stop;
            for (k = 0; k < 300 && ctl_flag !== 1'b1; k = k + 1) tick;
            check({ctl_flag, irq_n}, 2'h2);
            tick;
            check({st_det, dt_gen, dt_det, conc_on, rep_on, cap_on, play_on, fdx_on}, exp_ctl(v));
            rd_reg(`ADDR_CONTROL_MIRROR, 16, rd);
            check(rd, v);
            clear_flags;
            decoder_ready_in = 1'b1;
            tick;
            decoder_ready_in = 1'b0;
            tick;
            check(wanted_flag, v[4]);
        end
        irq_enable_in = 2'h1;
        for (i = 0; i < 2; i = i + 1) begin
            clear_flags;
            svc_ok_in = i[0];
            svc_done_in = 1'b1;
            tick;
            svc_done_in = 1'b0;
            tick;
            check({svc_flag, irq_n}, 2'h2);
            rd_reg(`ADDR_SERVICE_ACK, 8, rd);
            check(rd[0], i[0]);
        end
        vocoder_config_in = ($random(seed) & 8'hE3) | 8'h04;
        ft = $random(seed);
        for (i = 0; i < 2; i = i + 1) begin
            frame_types_in = i ? ~ft : ft;
            frame_types_valid_in = 1'b1;
            tick;
            frame_types_valid_in = 1'b0;
            rd_reg(`ADDR_FRAME_TYPES, 8, rd);
            check(rd[7:0], ft);
            vocoder_config_in = vocoder_config_in | 8'h10;
        end
        rd_reg(8'h55, 8, rd);
        check(rd[7:0], 8'h00);
        for (i = 0; i < 12; i = i + 1) begin
            vocoder_config_in = ($random(seed) & 8'hE0) | (i < 8 ?
                {4'h0, i[2] ? 2'b10 : 2'b01, i[1:0]} :
                {4'h1, i[0] ? 2'b10 : 2'b01, i[1] ? 2'b11 : 2'b00});
            n = exp_bytes(vocoder_config_in);
            clear_flags;
            for (k = 0; k < n; k = k + 1) begin
                bytes[k] = $random(seed);
                pkt_byte_in = bytes[k];
                pkt_byte_valid_in = 1'b1;
                tick;
            end
            pkt_byte_valid_in = 1'b0;
            tick;
            check(avail_flag, 1'b1);
            HOST.start(`ADDR_PACKET_STREAM);
            for (k = 0; k < n; k = k + 1) begin
                HOST.shift(8, 16'h0000, rd);
                check(rd[7:0], bytes[k]);
            end
            HOST.stop;
        end
        codec_fifo_sel_in = 1'b1;
        codec_fifo_word_in = $random(seed);
        pops = 0;
        rd_reg(`ADDR_PACKET_STREAM, 16, rd);
        check(rd, codec_fifo_word_in);
        check(pops, 1);
        codec_fifo_sel_in = 1'b0;
        complete_run;
    end
endmodule
